// File: adc_regs_pkg.sv
// constants shared by the status/mode register bank and its checksum helper
// assumes a 16-bit register word reached through a serial frame from the host
package adc_regs_pkg;

  // ==========================================================================
  // register addresses and reset values
  localparam logic [5:0]  ADDR_STATUS      = 6'h01;
  localparam logic [5:0]  ADDR_MODE        = 6'h02;
  localparam logic [15:0] STATUS_RST       = 16'h0500;
  localparam logic [15:0] MODE_RST         = 16'h0510;
  // writable mode bits; 15:14 and 7:5 are held at zero
  localparam logic [15:0] MODE_WR_MASK     = 16'h3f1f;

  // ==========================================================================
  // field positions, shared by both registers where they coincide
  localparam int LOCK_BIT    = 15;
  localparam int RESYNC_BIT  = 14;
  localparam int MAPCRC_BIT  = 13;
  localparam int RXCRC_BIT   = 12;
  localparam int CRCTYPE_BIT = 11;
  localparam int RESET_BIT   = 10;
  localparam int WLEN_HI     = 9;
  localparam int WLEN_LO     = 8;
  localparam int TIMEOUT_BIT = 4;
  localparam int NUM_CH      = 6;

  // ==========================================================================
  // serial frame layout
  localparam int        WORD_BITS  = 16;
  localparam logic [5:0] CMD_END   = 6'd15;
  localparam logic [5:0] DATA_END  = 6'd31;
  localparam logic [5:0] DATA_FIRST = 6'd16;
  localparam logic [5:0] FRAME_PLAIN = 6'd32;
  localparam logic [5:0] FRAME_CRC   = 6'd48;
  localparam int        CMD_RD_BIT = 15;

  // ==========================================================================
  // checksum polynomials and seed
  localparam logic [15:0] POLY_CCITT = 16'h1021;
  localparam logic [15:0] POLY_ANSI  = 16'h8005;
  localparam logic [15:0] CRC_SEED   = 16'hffff;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ     = 125;
  localparam int TIMEOUT_US  = 1000;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;

endpackage : adc_regs_pkg

// File: crc_if.sv
// carries one checksum step between the register bank and the checksum helper
// assumes a combinational helper on the calc side
`timescale 1ns/1ps
`default_nettype none
interface crc_if #(parameter int W = 16);
  logic [15:0]  crc_in;
  logic [W-1:0] data;
  logic         ansi;
  logic [15:0]  crc_out;
  modport calc (input crc_in, input data, input ansi, output crc_out);
  modport user (output crc_in, output data, output ansi, input crc_out);
endinterface : crc_if
`default_nettype wire

// File: crc16_step.sv
// advances a 16-bit checksum over W data bits, most significant bit first
// assumes the caller holds the running value; purely combinational
`timescale 1ns/1ps
`default_nettype none
module crc16_step
  import adc_regs_pkg::*;
#(
  parameter int W = 16
) (
  crc_if.calc port
);

  // ==========================================================================
  // bitwise shift-and-xor, unrolled by the tool over W
  always_comb begin
    logic [15:0] acc;
    logic [15:0] poly;
    acc  = port.crc_in;
    poly = port.ansi ? POLY_ANSI : POLY_CCITT;
    for (int i = W - 1; i >= 0; i--) begin
      if (acc[15] ^ port.data[i]) begin
        acc = {acc[14:0], 1'b0} ^ poly;
      end else begin
        acc = {acc[14:0], 1'b0};
      end
    end
    port.crc_out = acc;
  end

endmodule : crc16_step
`default_nettype wire

// File: adc_status_mode_regs.sv
// status and mode registers of the converter, reached over the serial port
// assumes the host sclk, cs_n and mosi are asynchronous and far slower than i_ref_clk
`timescale 1ns/1ps
`default_nettype none
// Contract
// (R01) status bit 15 shows interface lock, resets unlocked
// (R02) status bit 14 set on each resync
// (R03) status bit 13 set when map checksum changes
// (R04) status bit 12 set on input checksum error
// (R05) status bit 11 shows polynomial in use
// (R06) status bit 10 reset flag, reads 1 after reset
// (R07) status bits 9:8 show output word length
// (R08) status bits 5:0 flag new channel data
// (R09) reserved mode bits read zero, host writes zero
// (R10) mode bit 13 enables map checksum, default off
// (R11) mode bit 12 enables input checksum, default off
// (R12) mode bit 11 picks polynomial for both checksums
// (R13) writing 0 to mode bit 10 clears flag
// (R14) mode bits 9:8 select output word length
// (R15) mode register at 02h, resets to 0510h
// (R16) status register at 01h, resets to 0500h
// (R17) status word length, type mirror mode fields
// (R18) mode bit 4 enables interface timeout, default on
module adc_status_mode_regs
  import adc_regs_pkg::*;
#(
  parameter int P_TIMEOUT_CYC = TIMEOUT_CYC
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_sclk,
  input  wire logic              i_cs_n,
  input  wire logic              i_mosi,
  input  wire logic              i_if_lock,
  input  wire logic              i_resync,
  input  wire logic [NUM_CH-1:0] i_ch_new_sample,
  output logic                   o_miso,
  output logic [1:0]             o_word_size_sel,
  output logic                   o_reg_crc_en,
  output logic                   o_rx_crc_en,
  output logic                   o_crc_ansi,
  output logic                   o_timeout_en,
  output logic [3:0]             o_drdy_cfg,
  output logic                   o_frame_drop
);
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DEAD} frame_st_t;
  // ==========================================================================
  // pin synchronisers
  logic cs_n_s1_r;
  logic cs_n_s2_r;
  logic cs_n_s3_r;
  logic sclk_s1_r;
  logic sclk_s2_r;
  logic sclk_s3_r;
  logic mosi_s1_r;
  logic mosi_s2_r;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cs_n_s1_r <= 1'b1;
      cs_n_s2_r <= 1'b1;
      cs_n_s3_r <= 1'b1;
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
    end else begin
      cs_n_s1_r <= i_cs_n;
      cs_n_s2_r <= cs_n_s1_r;
      cs_n_s3_r <= cs_n_s2_r;
      sclk_s1_r <= i_sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      mosi_s1_r <= i_mosi;
      mosi_s2_r <= mosi_s1_r;
    end
  end
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  assign cs_fall   = cs_n_s3_r & ~cs_n_s2_r;
  assign cs_rise   = ~cs_n_s3_r & cs_n_s2_r;
  assign sclk_rise = ~sclk_s3_r & sclk_s2_r & ~cs_n_s2_r;
  assign sclk_fall = sclk_s3_r & ~sclk_s2_r & ~cs_n_s2_r;

  // ==========================================================================
  // frame state
  frame_st_t   st_r;
  logic [5:0]  bit_cnt_r;
  logic [31:0] idle_cnt_r;
  logic [15:0] mode_r;
  logic        timed_out;
  // the timeout only watches a selected frame, so a host that parks cs_n low forever loses the frame
  assign timed_out = mode_r[TIMEOUT_BIT] && (idle_cnt_r >= 32'(P_TIMEOUT_CYC)); // (R18)
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (cs_fall) begin
            st_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (cs_rise) begin
            st_r <= ST_IDLE;
          end else if (timed_out) begin
            st_r <= ST_DEAD;
          end
        end
        ST_DEAD: begin
          if (cs_rise) begin
            st_r <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      idle_cnt_r <= 32'h0;
    end else if (st_r != ST_SHIFT || sclk_rise || sclk_fall) begin
      idle_cnt_r <= 32'h0;
    end else if (idle_cnt_r != 32'hffffffff) begin
      idle_cnt_r <= idle_cnt_r + 32'h1;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_frame_drop <= 1'b0;
    end else begin
      o_frame_drop <= (st_r == ST_SHIFT) && !cs_rise && timed_out;
    end
  end

  // ==========================================================================
  // receive shifter, sampled on falling sclk
  logic [15:0] rx_sh_r;
  logic [15:0] cmd_r;
  logic [15:0] data_r;
  logic [15:0] rx_crc_r;
  logic        rx_bit_en;
  assign rx_bit_en = (st_r == ST_SHIFT) && sclk_fall;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bit_cnt_r <= 6'h00;
    end else if (cs_fall) begin
      bit_cnt_r <= 6'h00;
    end else if (rx_bit_en && bit_cnt_r != 6'h3f) begin
      bit_cnt_r <= bit_cnt_r + 6'h01;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_sh_r <= 16'h0000;
      cmd_r   <= 16'h0000;
      data_r  <= 16'h0000;
    end else if (cs_fall) begin
      rx_sh_r <= 16'h0000;
      cmd_r   <= 16'h0000;
      data_r  <= 16'h0000;
    end else if (rx_bit_en) begin
      rx_sh_r <= {rx_sh_r[14:0], mosi_s2_r};
      if (bit_cnt_r == CMD_END) begin
        cmd_r <= {rx_sh_r[14:0], mosi_s2_r};
      end
      if (bit_cnt_r == DATA_END) begin
        data_r <= {rx_sh_r[14:0], mosi_s2_r};
      end
    end
  end

  // running checksum over every received bit; a good trailing word leaves zero behind
  crc_if #(.W(1)) rx_crc_if ();
  assign rx_crc_if.crc_in = rx_crc_r;
  assign rx_crc_if.data   = mosi_s2_r;
  assign rx_crc_if.ansi   = mode_r[CRCTYPE_BIT]; // (R12)
  crc16_step #(.W(1)) u_rx_crc (
    .port (rx_crc_if.calc)
  );
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_crc_r <= CRC_SEED;
    end else if (cs_fall) begin
      rx_crc_r <= CRC_SEED;
    end else if (rx_bit_en) begin
      rx_crc_r <= rx_crc_if.crc_out;
    end
  end
  // ==========================================================================
  // frame commit at deselect
  logic       frame_end;
  logic       frame_ok;
  logic       crc_bad_evt;
  logic       wr_mode;
  logic       rd_status;
  logic [5:0] cmd_addr;
  assign frame_end = (st_r == ST_SHIFT) && cs_rise;
  assign cmd_addr  = cmd_r[5:0];
  always_comb begin
    if (mode_r[RXCRC_BIT]) begin
      frame_ok = (bit_cnt_r == FRAME_CRC) && (rx_crc_r == 16'h0000); // (R11)
    end else begin
      frame_ok = (bit_cnt_r >= FRAME_PLAIN);
    end
  end
  assign crc_bad_evt = frame_end && mode_r[RXCRC_BIT] && (bit_cnt_r >= FRAME_CRC) && !frame_ok; // (R04)
  assign wr_mode     = frame_end && frame_ok && !cmd_r[CMD_RD_BIT] && (cmd_addr == ADDR_MODE); // (R15)
  assign rd_status   = frame_end && frame_ok && cmd_r[CMD_RD_BIT] && (cmd_addr == ADDR_STATUS); // (R16)
  // ==========================================================================
  // mode register
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_r <= MODE_RST; // (R15)
    end else if (wr_mode) begin
      mode_r <= data_r & MODE_WR_MASK; // (R09) (R10) (R11) (R12) (R14) (R18)
    end
  end

  assign o_word_size_sel = mode_r[WLEN_HI:WLEN_LO]; // (R14)
  assign o_reg_crc_en    = mode_r[MAPCRC_BIT]; // (R10)
  assign o_rx_crc_en     = mode_r[RXCRC_BIT]; // (R11)
  assign o_crc_ansi      = mode_r[CRCTYPE_BIT]; // (R12)
  assign o_timeout_en    = mode_r[TIMEOUT_BIT]; // (R18)
  assign o_drdy_cfg      = mode_r[3:0];
  // ==========================================================================
  // status flags; a hardware set in the same cycle as a read clear wins
  logic              lock_r;
  logic              resync_r;
  logic              map_chg_r;
  logic              crc_err_r;
  logic              rst_flag_r;
  logic [NUM_CH-1:0] new_data_r;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lock_r <= 1'b0; // (R01)
    end else begin
      lock_r <= i_if_lock; // (R01)
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      resync_r <= 1'b0;
    end else if (i_resync) begin
      resync_r <= 1'b1; // (R02)
    end else if (rd_status) begin
      resync_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      crc_err_r <= 1'b0;
    end else if (crc_bad_evt) begin
      crc_err_r <= 1'b1; // (R04)
    end else if (rd_status) begin
      crc_err_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_flag_r <= 1'b1; // (R06)
    end else if (wr_mode && !data_r[RESET_BIT]) begin
      rst_flag_r <= 1'b0; // (R13)
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      new_data_r <= '0;
    end else begin
      new_data_r <= i_ch_new_sample | (new_data_r & ~{NUM_CH{rd_status}}); // (R08)
    end
  end

  // ==========================================================================
  // register-map checksum watch: re-armed after every legal write
  crc_if #(.W(16)) map_crc_if ();
  logic [15:0] map_ref_r;
  logic        map_arm_r;
  assign map_crc_if.crc_in = CRC_SEED;
  assign map_crc_if.data   = mode_r;
  assign map_crc_if.ansi   = mode_r[CRCTYPE_BIT]; // (R12)
  crc16_step #(.W(16)) u_map_crc (
    .port (map_crc_if.calc)
  );
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      map_ref_r <= 16'h0000;
      map_arm_r <= 1'b0;
    end else if (!mode_r[MAPCRC_BIT] || wr_mode) begin
      map_arm_r <= 1'b0; // (R10)
    end else if (!map_arm_r) begin
      map_ref_r <= map_crc_if.crc_out;
      map_arm_r <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      map_chg_r <= 1'b0;
    end else if (map_arm_r && mode_r[MAPCRC_BIT] && !wr_mode && map_crc_if.crc_out != map_ref_r) begin
      map_chg_r <= 1'b1; // (R03)
    end else if (rd_status) begin
      map_chg_r <= 1'b0;
    end
  end

  // ==========================================================================
  // read data and transmit shifter, driven on rising sclk
  logic [15:0] status_word;
  logic [15:0] rd_word;
  logic [15:0] tx_sh_r;
  always_comb begin
    status_word                  = 16'h0000;
    status_word[LOCK_BIT]        = lock_r; // (R01)
    status_word[RESYNC_BIT]      = resync_r; // (R02)
    status_word[MAPCRC_BIT]      = map_chg_r; // (R03)
    status_word[RXCRC_BIT]       = crc_err_r; // (R04)
    status_word[CRCTYPE_BIT]     = mode_r[CRCTYPE_BIT]; // (R05) (R17)
    status_word[RESET_BIT]       = rst_flag_r; // (R06)
    status_word[WLEN_HI:WLEN_LO] = mode_r[WLEN_HI:WLEN_LO]; // (R07) (R17)
    status_word[NUM_CH-1:0]      = new_data_r; // (R08)
  end

  // unmapped addresses read back as zero
  always_comb begin
    if (cmd_addr == ADDR_STATUS) begin
      rd_word = status_word; // (R16)
    end else if (cmd_addr == ADDR_MODE) begin
      rd_word = mode_r; // (R09)
    end else begin
      rd_word = 16'h0000;
    end
  end

  // the word is captured as its first bit leaves, so sticky flags set later in a status read frame are cleared unread at deselect
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_sh_r <= 16'h0000;
      o_miso  <= 1'b0;
    end else if (cs_fall || cs_rise) begin
      tx_sh_r <= 16'h0000;
      o_miso  <= 1'b0;
    end else if ((st_r == ST_SHIFT) && sclk_rise) begin
      if (bit_cnt_r == DATA_FIRST && cmd_r[CMD_RD_BIT]) begin
        o_miso  <= rd_word[WORD_BITS-1];
        tx_sh_r <= {rd_word[14:0], 1'b0};
      end else begin
        o_miso  <= tx_sh_r[WORD_BITS-1];
        tx_sh_r <= {tx_sh_r[14:0], 1'b0};
      end
    end
  end

endmodule : adc_status_mode_regs
`default_nettype wire

// File: adc_regs_props.sv
// concurrent checks on the ports of the status/mode register bank
// assumes one clock domain and binding to adc_status_mode_regs
`timescale 1ns/1ps
`default_nettype none
module adc_regs_props #(
  parameter int P_TIMEOUT_CYC = 200
) (
  input wire logic       i_ref_clk,
  input wire logic       i_rstn,
  input wire logic       i_sclk,
  input wire logic       i_cs_n,
  input wire logic       o_miso,
  input wire logic [1:0] o_word_size_sel,
  input wire logic       o_reg_crc_en,
  input wire logic       o_rx_crc_en,
  input wire logic       o_crc_ansi,
  input wire logic       o_timeout_en,
  input wire logic       o_frame_drop
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // ==========
  // idle time at the pins, so the drop is judged without the sync lag
  logic        sclk_q_r;
  logic [15:0] idle_r;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sclk_q_r <= 1'b0;
      idle_r   <= 16'h0000;
    end else begin
      sclk_q_r <= i_sclk;
      if (i_cs_n || i_sclk != sclk_q_r)
        idle_r <= 16'h0000;
      else if (idle_r != 16'hffff)
        idle_r <= idle_r + 16'h0001;
    end
  end
  // ==========
  // mode outputs move only after a frame closes; also reset values, idle read line and frame drop
  property p_wlen_hold; !i_cs_n [*6] |=> $stable(o_word_size_sel); endproperty
  a_wlen_hold: assert property (p_wlen_hold) else $error("word size moved in frame");
  property p_rx_hold; !i_cs_n [*6] |=> $stable(o_rx_crc_en); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("input check enable moved in frame");
  property p_ansi_chg; $changed(o_crc_ansi) |-> $past(i_cs_n, 2); endproperty
  a_ansi_chg: assert property (p_ansi_chg) else $error("polynomial moved in frame");
  property p_regen_chg; $changed(o_reg_crc_en) |-> $past(i_cs_n, 3); endproperty
  a_regen_chg: assert property (p_regen_chg) else $error("map check enable moved in frame");
  property p_tmo_chg; $changed(o_timeout_en) |-> i_cs_n && $past(i_cs_n, 2); endproperty
  a_tmo_chg: assert property (p_tmo_chg) else $error("timeout enable moved in frame");
  property p_rst_vals;
    $rose(i_rstn) |-> o_word_size_sel == 2'b01 && o_timeout_en && !o_reg_crc_en && !o_rx_crc_en && !o_crc_ansi;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("mode outputs wrong after reset");
  property p_miso_idle; i_cs_n [*8] |-> !o_miso; endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("read line driven outside frame");
  property p_drop_once; o_frame_drop |=> !o_frame_drop [*8]; endproperty
  a_drop_once: assert property (p_drop_once) else $error("frame drop repeated");
  property p_drop_cause; o_frame_drop |-> o_timeout_en && idle_r >= P_TIMEOUT_CYC - 4; endproperty
  a_drop_cause: assert property (p_drop_cause) else $error("frame dropped without timeout");
  c_drop: cover property (o_frame_drop);
  c_ansi: cover property ($rose(o_crc_ansi));
  c_tmo_off: cover property ($fell(o_timeout_en));
endmodule : adc_regs_props
`default_nettype wire

// File: spi_host_model.sv
// serial host: sends mode 1 frames msb first and shifts in the reply word
// assumes its tasks are called from the bench; sclk period is 10 ref clocks
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic i_ref_clk,
  input  wire logic i_miso,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_mosi
);
  // sclk stands low between frames
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // ==========
  // n bits of w, then stall clocks with cs_n still low
  task automatic xfer(input int n, input logic [47:0] w, input int stall, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge i_ref_clk);
    o_cs_n = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    for (int k = 0; k < n; k++) begin
      o_sclk = 1'b1;
      o_mosi = w[47-k];
      repeat (5) @(negedge i_ref_clk);
      if (k >= 16 && k < 32)
        rd = {rd[14:0], i_miso};
      o_sclk = 1'b0;
      repeat (5) @(negedge i_ref_clk);
    end
    repeat (stall) @(negedge i_ref_clk);
    o_cs_n = 1'b1;
    // released line must not keep the last bit
    o_mosi = ~o_mosi;
    repeat (6) @(negedge i_ref_clk);
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// File: test_adc_status_mode_regs.sv
// self-checking bench for the status/mode register bank
// assumes a shortened frame timeout of P_TMO reference clocks
`timescale 1ns/1ps
`default_nettype none
module test_adc_status_mode_regs;
  import adc_regs_pkg::*;
  localparam int P_TMO = 200;
  logic       i_ref_clk, i_rstn, i_sclk, i_cs_n, i_mosi, i_if_lock, i_resync, o_miso;
  logic [5:0] i_ch_new_sample;
  logic [1:0] o_word_size_sel;
  logic       o_reg_crc_en, o_rx_crc_en, o_crc_ansi, o_timeout_en, o_frame_drop;
  logic [3:0] o_drdy_cfg;
  logic [9:0] mode_outs;
  logic       crc_on, ansi_on;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         n_drop = 0;
  assign mode_outs = {o_reg_crc_en, o_rx_crc_en, o_crc_ansi, o_timeout_en, o_word_size_sel, o_drdy_cfg};
  adc_status_mode_regs #(.P_TIMEOUT_CYC(P_TMO)) adc_status_mode_regs_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_mosi(i_mosi), .i_if_lock(i_if_lock), .i_resync(i_resync),
    .i_ch_new_sample(i_ch_new_sample), .o_miso(o_miso), .o_word_size_sel(o_word_size_sel),
    .o_reg_crc_en(o_reg_crc_en), .o_rx_crc_en(o_rx_crc_en), .o_crc_ansi(o_crc_ansi),
    .o_timeout_en(o_timeout_en), .o_drdy_cfg(o_drdy_cfg), .o_frame_drop(o_frame_drop));
  spi_host_model spi_host_model_i (.i_ref_clk(i_ref_clk), .i_miso(o_miso), .o_sclk(i_sclk), .o_cs_n(i_cs_n),
    .o_mosi(i_mosi));
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) if (o_frame_drop === 1'b1) n_drop++;
  // ==========
  // helpers
  function automatic logic [15:0] crc16(input logic [31:0] d, input logic ansi);
    logic [15:0] c;
    c = CRC_SEED;
    for (int k = 31; k >= 0; k--)
      c = (c[15] ^ d[k]) ? ((c << 1) ^ (ansi ? POLY_ANSI : POLY_CCITT)) : (c << 1);
    return c;
  endfunction : crc16
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic frame(input logic [15:0] cmd, input logic [15:0] d, input logic bad, output logic [15:0] rd);
    logic [15:0] c;
    c = crc16({cmd, d}, ansi_on) ^ {15'h0000, bad};
    spi_host_model_i.xfer(crc_on ? 48 : 32, {cmd, d, c}, 0, rd);
  endtask : frame
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] r;
    frame({10'h000, a}, d, 1'b0, r);
    if (a == ADDR_MODE) begin
      crc_on = d[12];
      ansi_on = d[11];
    end
  endtask : wr
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] r;
    frame({10'h200, a}, 16'h0000, 1'b0, r);
    chk(r, exp);
  endtask : rd_chk
  task automatic mode_chk(input logic [15:0] m);
    chk({6'h00, mode_outs}, {6'h00, m[13], m[12], m[11], m[4], m[9:8], m[3:0]});
  endtask : mode_chk
  // ==========
  // scenarios
  task automatic t_reset_vals;
    rd_chk(ADDR_STATUS, 16'h0500);
    rd_chk(ADDR_MODE, 16'h0510);
    mode_chk(16'h0510);
    rd_chk(6'h05, 16'h0000);
    wr(ADDR_STATUS, 16'hffff);
    rd_chk(ADDR_STATUS, 16'h0500);
  endtask : t_reset_vals
  task automatic t_modes;
    logic [15:0] m;
    for (int w = 0; w < 4; w++) begin
      m = 16'h0400 | 16'(w << 8) | (w[0] ? 16'h0800 : 16'h0000) | (w[1] ? 16'h0010 : 16'h0000) | 16'(w);
      wr(ADDR_MODE, m);
      rd_chk(ADDR_MODE, m);
      rd_chk(ADDR_STATUS, m & 16'h0f00);
      mode_chk(m);
    end
  endtask : t_modes
  task automatic t_crc;
    logic [15:0] r;
    wr(ADDR_MODE, 16'hffff);
    rd_chk(ADDR_MODE, 16'h3f1f);
    frame({10'h000, ADDR_MODE}, 16'h0410, 1'b1, r);
    rd_chk(ADDR_MODE, 16'h3f1f);
    rd_chk(ADDR_STATUS, 16'h1f00);
    rd_chk(ADDR_STATUS, 16'h0f00);
    wr(ADDR_MODE, 16'h0110);
    rd_chk(ADDR_STATUS, 16'h0100);
    mode_chk(16'h0110);
  endtask : t_crc
  task automatic t_sticky;
    @(negedge i_ref_clk);
    i_if_lock = 1'b1;
    i_resync = 1'b1;
    i_ch_new_sample = 6'h2a;
    @(negedge i_ref_clk);
    i_resync = 1'b0;
    i_ch_new_sample = 6'h15;
    @(negedge i_ref_clk);
    i_ch_new_sample = 6'h00;
    rd_chk(ADDR_STATUS, 16'hc13f);
    rd_chk(ADDR_STATUS, 16'h8100);
    i_if_lock = 1'b0;
    rd_chk(ADDR_STATUS, 16'h0100);
  endtask : t_sticky
  task automatic t_timeout;
    logic [15:0] r;
    spi_host_model_i.xfer(8, 48'h0, P_TMO + 60, r);
    chk(16'(n_drop), 16'h0001);
    wr(ADDR_MODE, 16'h0100);
    spi_host_model_i.xfer(8, 48'h0, P_TMO + 60, r);
    chk(16'(n_drop), 16'h0001);
    rd_chk(ADDR_MODE, 16'h0100);
  endtask : t_timeout
  task automatic end_of_test;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  initial begin
    i_rstn = 1'b0;
    i_if_lock = 1'b0;
    i_resync = 1'b0;
    i_ch_new_sample = 6'h00;
    crc_on = 1'b0;
    ansi_on = 1'b0;
    repeat (12) @(negedge i_ref_clk);
    i_rstn = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    t_reset_vals();
    t_modes();
    t_crc();
    t_sticky();
    t_timeout();
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge i_ref_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule : test_adc_status_mode_regs
bind adc_status_mode_regs adc_regs_props #(.P_TIMEOUT_CYC(P_TIMEOUT_CYC)) adc_regs_props_i (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .o_miso(o_miso),
  .o_word_size_sel(o_word_size_sel), .o_reg_crc_en(o_reg_crc_en), .o_rx_crc_en(o_rx_crc_en),
  .o_crc_ansi(o_crc_ansi), .o_timeout_en(o_timeout_en), .o_frame_drop(o_frame_drop));
`default_nettype wire
